// file: core/rlc_consts.svh
// Constants of the relay load control block: timing, register map, reset values.
// Assumes it is included by bare name from the design files.
`ifndef RLC_CONSTS_SVH
`define RLC_CONSTS_SVH
`define RLC_CLK_HZ 50000000
`define RLC_TICK_S 1
`define RLC_BTN_HOLD_S 3
`define RLC_OP_A 0
`define RLC_OP_B 1
`define RLC_OP_C 2
`define RLC_OP_D 3
`define RLC_OP_E 4
`define RLC_OP_F 5
`define RLC_OP_G 6
`define RLC_OP_H 7
`define RLC_OP_I 8
`define RLC_OP_J 9
`define RLC_OP_K 10
`define RLC_OP_L 11
`define RLC_OP_M 12
`define RLC_OP_N 13
`define RLC_OP_R 14
`define RLC_MASK_M1 15'h7e7f
`define RLC_MASK_M2 15'h7ff3
`define RLC_MASK_M3 15'h7e3f
`define RLC_MASK_M4 15'h7fb3
`define RLC_ADDR_CTRL 8'h00
`define RLC_ADDR_THR_NORM 8'h04
`define RLC_ADDR_THR_EMRG 8'h08
`define RLC_ADDR_OVL_DELAY 8'h0c
`define RLC_ADDR_RECLOSE 8'h10
`define RLC_ADDR_LOCK_CNT 8'h14
`define RLC_ADDR_PON_WIN 8'h18
`define RLC_ADDR_STATUS 8'h1c
`define RLC_RST_MODE 3'h1
`define RLC_RST_THR_NORM 16'h1000
`define RLC_RST_THR_EMRG 16'h0800
`define RLC_RST_OVL_DELAY 16'h003c
`define RLC_RST_RECLOSE 16'h003c
`define RLC_RST_LOCK_CNT 8'h03
`define RLC_PON_WIN_DEF 8'h0f
`define RLC_PON_WIN_MIN 8'h0a
`define RLC_PON_WIN_MAX 8'h3c
`define RLC_LFSR_SEED 16'hace1
`endif

// file: core/rlc_pkg.sv
// Types shared by the relay load control block.
// Assumes nothing of its surroundings.
package rlc_pkg;
    typedef enum logic [1:0] {
        RLC_OPEN,
        RLC_CLOSED,
        RLC_LOCKED,
        RLC_PENDING
    } rlc_state_t;

    typedef struct packed {
        logic force_connect;
        logic remote_disconnect;
        logic remote_connect;
        logic sched_disconnect;
        logic sched_connect;
    } rlc_cmd_t;

    typedef struct packed {
        logic relay_close;
        logic emerg_lock;
        logic [1:0] state;
    } rlc_status_t;
endpackage : rlc_pkg

// file: core/rlc_tick.sv
// One-second enable divider.
// Assumes a free running sys_clk at the rate given by the parameter.
`timescale 1ns/1ps
`default_nettype none
`include "rlc_consts.svh"
module rlc_tick #(
    parameter int unsigned CYCLES = `RLC_CLK_HZ * `RLC_TICK_S
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    output logic tick
);
    logic [31:0] cnt;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 32'h0;
            tick <= 1'b0;
        end else if (cnt == 32'(CYCLES - 1)) begin
            cnt <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule : rlc_tick
`default_nettype wire

// file: core/rlc_overload.sv
// Overload delay counter: up/down per second, trip pulse past the delay.
// Assumes tick is a one-cycle enable and en is high only while closed.
`timescale 1ns/1ps
`default_nettype none
module rlc_overload #(
    parameter int W = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic en,
    input wire logic clr,
    input wire logic over,
    input wire logic [W-1:0] delay,
    output logic trip,
    output logic [W-1:0] count
);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (clr) begin
            count <= '0; // see R19
        end else if (en && tick) begin
            if (over && count != '1) begin
                count <= count + 1'b1; // see R16
            end else if (!over && count != '0) begin
                count <= count - 1'b1; // see R16
            end
        end
    end

    // Held in reset-like idle while disabled so an open relay never trips.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            trip <= 1'b0;
        end else begin
            trip <= en && !clr && !trip && (count > delay); // see R17 see R18
        end
    end
endmodule : rlc_overload
`default_nettype wire

// file: core/rlc_relay_ctrl.sv
// Relay load control: four-state control machine with APB registers.
// Assumes commands are one-cycle pulses and the button is a clean level.
// Notes on behaviour
// R1: Status is open 0, closed 1, locked 2, pending reclose 3.
// R2: Open state waits for a remote, scheduled or force connect before any operation.
// R3: Locked state keeps the relay open and closes it automatically only on emergency release.
// R4: Pending state closes automatically after the reclose period.
// R5: Remote or scheduled disconnect opens the relay from any state.
// R6: Remote or scheduled connect takes path c/d or h/i by mode.
// R7: Closed with load over threshold trips to pending reclose.
// R8: Three second button hold in locked or pending closes the relay.
// R9: After the set number of trips, normal lockout enters locked.
// R10: In emergency the lockout also sets the emergency lock flag.
// R11: Locked with emergency flag closes when the emergency period ends.
// R12: Three second button hold while closed opens into locked if allowed.
// R13: Force connect closes the relay in modes 1 to 4, not in protection mode 0 or in modes 5 to 7.
// R14: Mode 0 is protection mode and refuses every transition.
// R15: Each mode permits only its own set of transitions.
// R16: Overload counter counts up when over, down to zero otherwise.
// R17: Counter above the delay logs an overload and trips the relay.
// R18: Overload judgement is suspended while the relay is open.
// R19: Closing the relay clears the overload counter.
// R20: Emergency period selects the emergency threshold, else the normal one.
// R21: After power return a pending relay closes at a random time in window.
// R22: Reported relay status mirrors the control status.
// R23: A one-second tick times all delays of the block.
`timescale 1ns/1ps
`default_nettype none
`include "rlc_consts.svh"
module rlc_relay_ctrl #(
    parameter int unsigned TICK_CYCLES = `RLC_CLK_HZ * `RLC_TICK_S,
    parameter int W = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rlc_pkg::rlc_cmd_t cmd,
    input wire logic button_held,
    input wire logic [W-1:0] apparent_power,
    input wire logic emergency,
    input wire logic power_restored,
    output logic overload_event,
    output rlc_pkg::rlc_status_t status
);
    ////////////////////////////////////////////////////////////////////////
    rlc_pkg::rlc_state_t state;
    rlc_pkg::rlc_state_t next_state;
    logic [2:0] mode;
    logic [W-1:0] thr_norm;
    logic [W-1:0] thr_emrg;
    logic [W-1:0] ovl_delay;
    logic [W-1:0] reclose_period;
    logic [7:0] lock_cnt;
    logic [7:0] pon_win;
    logic [7:0] trip_cnt;
    logic [W-1:0] ovl_count;
    logic [W-1:0] reclose_cnt;
    logic [1:0] btn_cnt;
    logic btn_done;
    logic btn_fire;
    logic emerg_lock;
    logic emerg_d;
    logic pon_pend;
    logic [7:0] pon_cnt;
    logic [7:0] pon_target;
    logic [15:0] lfsr;
    logic tick;
    logic trip;
    logic over;
    logic entering_closed;
    logic auto_close;
    logic lockout;
    logic next_emerg_lock;

    // Mode gating is used for every path, so it lives in one decoder.
    function automatic logic allowed(input logic [2:0] m, input int op);
        logic [14:0] mask;
        case (m)
            3'h1: mask = `RLC_MASK_M1;
            3'h2: mask = `RLC_MASK_M2;
            3'h3: mask = `RLC_MASK_M3;
            3'h4: mask = `RLC_MASK_M4;
            default: mask = 15'h0; // see R14
        endcase
        return mask[op]; // see R15
    endfunction : allowed

    ////////////////////////////////////////////////////////////////////////
    rlc_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tick(tick) // see R23
    );

    assign over = apparent_power > (emergency ? thr_emrg : thr_norm); // see R20

    rlc_overload #(
        .W(W)
    ) u_ovl (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tick(tick),
        .en(state == rlc_pkg::RLC_CLOSED), // see R18
        .clr(entering_closed), // see R19
        .over(over),
        .delay(ovl_delay),
        .trip(trip),
        .count(ovl_count)
    );

    assign overload_event = trip; // see R17

    ////////////////////////////////////////////////////////////////////////
    // Button hold: fires once per press after three ticks of hold.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            btn_cnt <= 2'h0;
            btn_done <= 1'b0;
        end else if (!button_held) begin
            btn_cnt <= 2'h0;
            btn_done <= 1'b0;
        end else if (btn_fire) begin
            btn_done <= 1'b1;
        end else if (tick && !btn_done) begin
            btn_cnt <= btn_cnt + 2'h1;
        end
    end

    assign btn_fire = button_held && !btn_done && tick &&
        (btn_cnt == 2'(`RLC_BTN_HOLD_S - 1)); // see R8 see R12

    // Reclose timer runs only while pending.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reclose_cnt <= '0;
        end else if (state != rlc_pkg::RLC_PENDING) begin
            reclose_cnt <= '0;
        end else if (tick && reclose_cnt != '1) begin
            reclose_cnt <= reclose_cnt + 1'b1; // see R4
        end
    end

    // Free-running LFSR gives the power-on random delay.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lfsr <= `RLC_LFSR_SEED;
        end else begin
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        end
    end

    // Power return scales a random byte into the window, at least one second.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pon_pend <= 1'b0;
            pon_cnt <= 8'h0;
            pon_target <= 8'h0;
        end else if (power_restored && state == rlc_pkg::RLC_PENDING) begin
            pon_pend <= 1'b1; // see R21
            pon_cnt <= 8'h0;
            pon_target <= 8'((16'(lfsr[7:0]) * 16'(pon_win)) >> 8) + 8'h1;
        end else if (state != rlc_pkg::RLC_PENDING) begin
            pon_pend <= 1'b0;
        end else if (pon_pend && tick && pon_cnt != 8'hff) begin
            pon_cnt <= pon_cnt + 8'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Priority: force, disconnect, connect, release, button, trip, auto.
    always_comb begin
        next_state = state;
        auto_close = 1'b0;
        lockout = 1'b0;
        next_emerg_lock = emerg_lock;
        if (cmd.force_connect && allowed(mode, `RLC_OP_R)) begin
            next_state = rlc_pkg::RLC_CLOSED; // see R13
        end else if ((cmd.remote_disconnect && allowed(mode, `RLC_OP_A)) ||
                     (cmd.sched_disconnect && allowed(mode, `RLC_OP_B))) begin
            next_state = rlc_pkg::RLC_OPEN; // see R5
        end else if (cmd.remote_connect && state != rlc_pkg::RLC_CLOSED &&
                     allowed(mode, `RLC_OP_C)) begin
            next_state = rlc_pkg::RLC_CLOSED; // see R2 see R6
        end else if (cmd.remote_connect && state != rlc_pkg::RLC_CLOSED &&
                     allowed(mode, `RLC_OP_H)) begin
            next_state = rlc_pkg::RLC_LOCKED; // see R6
        end else if (cmd.sched_connect && state != rlc_pkg::RLC_CLOSED &&
                     allowed(mode, `RLC_OP_D)) begin
            next_state = rlc_pkg::RLC_CLOSED; // see R2 see R6
        end else if (cmd.sched_connect && state != rlc_pkg::RLC_CLOSED &&
                     allowed(mode, `RLC_OP_I)) begin
            next_state = rlc_pkg::RLC_LOCKED; // see R6
        end else if (state == rlc_pkg::RLC_LOCKED && emerg_lock &&
                     emerg_d && !emergency &&
                     allowed(mode, `RLC_OP_M)) begin
            next_state = rlc_pkg::RLC_CLOSED; // see R11
        end else if (btn_fire && state == rlc_pkg::RLC_CLOSED &&
                     allowed(mode, `RLC_OP_G)) begin
            next_state = rlc_pkg::RLC_LOCKED; // see R12
        end else if (btn_fire && (state == rlc_pkg::RLC_LOCKED ||
                     state == rlc_pkg::RLC_PENDING) &&
                     allowed(mode, `RLC_OP_E)) begin
            next_state = rlc_pkg::RLC_CLOSED; // see R8
        end else if (trip && state == rlc_pkg::RLC_CLOSED &&
                     allowed(mode, `RLC_OP_F)) begin
            if (trip_cnt + 8'h1 >= lock_cnt) begin
                if (emergency && allowed(mode, `RLC_OP_L)) begin
                    next_state = rlc_pkg::RLC_LOCKED; // see R10
                    next_emerg_lock = 1'b1; // see R10
                    lockout = 1'b1;
                end else if (!emergency && allowed(mode, `RLC_OP_J)) begin
                    next_state = rlc_pkg::RLC_LOCKED; // see R9
                    lockout = 1'b1;
                end else begin
                    next_state = rlc_pkg::RLC_PENDING; // see R7
                end
            end else begin
                next_state = rlc_pkg::RLC_PENDING; // see R7
            end
        end else if (state == rlc_pkg::RLC_PENDING && pon_pend &&
                     pon_cnt >= pon_target && allowed(mode, `RLC_OP_N)) begin
            next_state = rlc_pkg::RLC_CLOSED; // see R21
            auto_close = 1'b1;
        end else if (state == rlc_pkg::RLC_PENDING && !pon_pend &&
                     reclose_cnt >= reclose_period &&
                     allowed(mode, `RLC_OP_K)) begin
            next_state = rlc_pkg::RLC_CLOSED; // see R4
            auto_close = 1'b1;
        end
        // Locked state stays put unless one of the paths above moves it.
        if (next_state != rlc_pkg::RLC_LOCKED) begin
            next_emerg_lock = 1'b0; // see R3
        end
    end

    assign entering_closed = (next_state == rlc_pkg::RLC_CLOSED) &&
        (state != rlc_pkg::RLC_CLOSED);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= rlc_pkg::RLC_OPEN;
            emerg_lock <= 1'b0;
            emerg_d <= 1'b0;
        end else begin
            state <= next_state; // see R1
            emerg_lock <= next_emerg_lock;
            emerg_d <= emergency;
        end
    end

    // Trip history survives auto reclose but is cleared by any other close.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            trip_cnt <= 8'h0;
        end else if (lockout || (entering_closed && !auto_close)) begin
            trip_cnt <= 8'h0;
        end else if (next_state == rlc_pkg::RLC_PENDING &&
                     state == rlc_pkg::RLC_CLOSED && trip_cnt != 8'hff) begin
            trip_cnt <= trip_cnt + 8'h1; // see R9
        end
    end

    // No contact sense: the relay drive and status follow the control state.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= '0;
        end else begin
            status.relay_close <= next_state == rlc_pkg::RLC_CLOSED; // see R22
            status.emerg_lock <= next_emerg_lock;
            status.state <= next_state; // see R22
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data captured in the setup cycle.
    logic wr_en;
    logic mapped;

    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;

    always_comb begin
        case (paddr)
            `RLC_ADDR_CTRL, `RLC_ADDR_THR_NORM, `RLC_ADDR_THR_EMRG,
            `RLC_ADDR_OVL_DELAY, `RLC_ADDR_RECLOSE, `RLC_ADDR_LOCK_CNT,
            `RLC_ADDR_PON_WIN, `RLC_ADDR_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= `RLC_RST_MODE;
            thr_norm <= `RLC_RST_THR_NORM;
            thr_emrg <= `RLC_RST_THR_EMRG;
            ovl_delay <= `RLC_RST_OVL_DELAY;
            reclose_period <= `RLC_RST_RECLOSE;
            lock_cnt <= `RLC_RST_LOCK_CNT;
            pon_win <= `RLC_PON_WIN_DEF;
        end else if (wr_en) begin
            case (paddr)
                `RLC_ADDR_CTRL: mode <= pwdata[2:0]; // see R15
                `RLC_ADDR_THR_NORM: thr_norm <= pwdata[W-1:0];
                `RLC_ADDR_THR_EMRG: thr_emrg <= pwdata[W-1:0];
                `RLC_ADDR_OVL_DELAY:
                    ovl_delay <= (pwdata[W-1:0] == '0) ? W'(1) : pwdata[W-1:0];
                `RLC_ADDR_RECLOSE: reclose_period <= pwdata[W-1:0];
                `RLC_ADDR_LOCK_CNT: lock_cnt <= pwdata[7:0];
                `RLC_ADDR_PON_WIN: begin
                    // Out-of-range window values clamp rather than fault.
                    if (pwdata[31:8] == 24'h0 && pwdata[7:0] < `RLC_PON_WIN_MIN) begin
                        pon_win <= `RLC_PON_WIN_MIN;
                    end else if (pwdata[31:8] != 24'h0 ||
                                 pwdata[7:0] > `RLC_PON_WIN_MAX) begin
                        pon_win <= `RLC_PON_WIN_MAX;
                    end else begin
                        pon_win <= pwdata[7:0]; // see R21
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `RLC_ADDR_CTRL: prdata <= {29'h0, mode};
                `RLC_ADDR_THR_NORM: prdata <= 32'(thr_norm);
                `RLC_ADDR_THR_EMRG: prdata <= 32'(thr_emrg);
                `RLC_ADDR_OVL_DELAY: prdata <= 32'(ovl_delay);
                `RLC_ADDR_RECLOSE: prdata <= 32'(reclose_period);
                `RLC_ADDR_LOCK_CNT: prdata <= {24'h0, lock_cnt};
                `RLC_ADDR_PON_WIN: prdata <= {24'h0, pon_win};
                `RLC_ADDR_STATUS: prdata <= {ovl_count[15:0], trip_cnt,
                    4'h0, pon_pend, emerg_lock, state}; // see R22
                default: prdata <= 32'h0;
            endcase
        end
    end
endmodule : rlc_relay_ctrl
`default_nettype wire

// file: testbench/rlc_relay_ctrl_properties.sv
// Port checker of the relay load control block.
// Assumes a bind into rlc_relay_ctrl; mode is written only at offset 0x00.
`timescale 1ns/1ps
`default_nettype none
module rlc_relay_ctrl_properties (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire rlc_pkg::rlc_cmd_t cmd,
    input wire logic button_held,
    input wire logic emergency,
    input wire logic overload_event,
    input wire rlc_pkg::rlc_status_t status
);
    // Mode is not visible at the ports, so it is shadowed from bus writes.
    logic [2:0] mode;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= 3'h1;
        end else if (psel && penable && pwrite && paddr == 8'h00) begin
            mode <= pwdata[2:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    relay_mirror_a: assert property (status.relay_close == (status.state == 2'h1))
        else $error("relay not mirrored");
    disconnect_open_a: assert property ((cmd.remote_disconnect || cmd.sched_disconnect)
        && !cmd.force_connect && mode != 3'h0 |=> status.state == 2'h0)
        else $error("disconnect ignored");
    force_close_a: assert property (cmd.force_connect && mode != 3'h0 |=> status.state == 2'h1)
        else $error("force ignored");
    protect_freeze_a: assert property (mode == 3'h0 |=> $stable(status.state))
        else $error("protection broken");
    connect_path_a: assert property (cmd == 5'b00100 && status.state == 2'h0
        && (mode == 3'h1 || mode == 3'h3) |=> status.state == 2'h1)
        else $error("wrong connect path");
    locked_hold_a: assert property (status.state == 2'h2 && !status.emerg_lock
        && !button_held && cmd == 5'h00 |=> status.state != 2'h1)
        else $error("locked relay closed");
    open_no_trip_a: assert property ((status.state != 2'h1) [*2] |-> !overload_event)
        else $error("event while open");
    trip_leave_a: assert property (overload_event |-> ##[0:1] status.state inside {2'h2, 2'h3})
        else $error("event without trip");
    emerg_release_a: assert property ($fell(emergency) && status.state == 2'h2
        && status.emerg_lock && mode != 3'h0 |-> ##[1:3] status.state == 2'h1)
        else $error("no emergency release");
    emerg_flag_a: assert property ($rose(status.emerg_lock) |-> status.state == 2'h2)
        else $error("flag outside locked");
    cover property (overload_event);
    cover property (status.state == 2'h3 ##1 status.state == 2'h1);
    cover property ($fell(emergency) && status.emerg_lock);
endmodule : rlc_relay_ctrl_properties
bind rlc_relay_ctrl rlc_relay_ctrl_properties rlc_props_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .cmd(cmd), .button_held(button_held),
    .emergency(emergency), .overload_event(overload_event), .status(status));
`default_nettype wire

// file: testbench/rlc_far_end.sv
// Far side model: head-end command pulses and the push button.
// Assumes its outputs feed cmd and button_held of the relay block.
`timescale 1ns/1ps
`default_nettype none
module rlc_far_end (
    input wire logic sys_clk,
    output var rlc_pkg::rlc_cmd_t cmd,
    output var logic button_held
);
    initial begin
        cmd = '0;
        button_held = 1'b0;
    end
    task automatic send(input rlc_pkg::rlc_cmd_t c);
        @(posedge sys_clk);
        cmd <= c;
        @(posedge sys_clk);
        cmd <= '0;
    endtask : send
    task automatic press(input int n);
        @(posedge sys_clk);
        button_held <= 1'b1;
        repeat (n) @(posedge sys_clk);
        button_held <= 1'b0;
    endtask : press
endmodule : rlc_far_end
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the relay load control block.
// Assumes a ten cycle tick and the far side model rlc_far_end.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, button_held, overload_event;
    rlc_pkg::rlc_cmd_t cmd;
    rlc_pkg::rlc_status_t status;
    logic [15:0] power = 16'h0000;
    logic emergency = 1'b0, power_restored = 1'b0;
    int n_errors = 0, tests_run = 0, n_evt = 0, cycles = 0;
    rlc_far_end rlc_far_end_i (.sys_clk(sys_clk), .cmd(cmd), .button_held(button_held));
    rlc_relay_ctrl #(.TICK_CYCLES(10), .W(16)) rlc_relay_ctrl_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmd(cmd), .button_held(button_held), .apparent_power(power), .emergency(emergency),
        .power_restored(power_restored), .overload_event(overload_event), .status(status));
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    always @(posedge sys_clk) begin
        cycles++;
        if (overload_event === 1'b1) n_evt++;
        if (cycles == 5000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic pulse(input logic [4:0] c);
        rlc_far_end_i.send(c);
        #1;
    endtask : pulse
    task automatic wait_st(input string nm, input logic [1:0] e, input int n);
        int i = 0;
        #1;
        while (status.state !== e && i < n) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        chk(nm, status.state, e);
    endtask : wait_st
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        chk("status at reset", status, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        chk("mode at reset", rd, 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", err, 32'h1);
        $display("reset done");
        for (int m = 1; m <= 4; m++) begin
            apb(1'b1, 8'h00, m);
            pulse(5'b00001);
            chk("sched connect", status.state, 32'(2 - m % 2));
            pulse(5'b01000);
            chk("remote disconnect", status.state, 32'h0);
            pulse(5'b00100);
            chk("remote connect", status.state, 32'(2 - m % 2));
            pulse(5'b00010);
            chk("sched disconnect", status.state, 32'h0);
        end
        $display("modes done");
        apb(1'b1, 8'h0c, 32'h3);
        apb(1'b1, 8'h14, 32'h2);
        apb(1'b1, 8'h10, 32'h2);
        @(posedge sys_clk) power <= 16'hffff;
        wait_st("open idle", 2'h0, 0);
        repeat (60) @(posedge sys_clk);
        wait_st("open stays open", 2'h0, 0);
        chk("no event while open", n_evt, 32'h0);
        apb(1'b1, 8'h00, 32'h0);
        pulse(5'b10000);
        chk("force in mode 0", status.state, 32'h0);
        apb(1'b1, 8'h00, 32'h1);
        pulse(5'b10000);
        chk("force connect", status.state, 32'h1);
        wait_st("overload trip", 2'h3, 200);
        repeat (2) @(posedge sys_clk);
        chk("overload event", n_evt, 32'h1);
        @(posedge sys_clk) power <= 16'h0000;
        wait_st("auto reclose", 2'h1, 100);
        apb(1'b0, 8'h1c, 32'h0);
        chk("counter cleared", rd[31:16], 32'h0);
        @(posedge sys_clk) power <= 16'hffff;
        wait_st("normal lockout", 2'h2, 200);
        chk("no emergency flag", status.emerg_lock, 32'h0);
        @(posedge sys_clk) power <= 16'h0000;
        repeat (60) @(posedge sys_clk);
        wait_st("stays locked", 2'h2, 0);
        rlc_far_end_i.press(40);
        wait_st("button close", 2'h1, 0);
        rlc_far_end_i.press(40);
        wait_st("button open", 2'h2, 0);
        $display("overload done");
        @(posedge sys_clk) power <= 16'h0c00;
        emergency <= 1'b1;
        pulse(5'b10000);
        wait_st("emergency trip", 2'h3, 200);
        wait_st("emergency lockout", 2'h2, 300);
        chk("emergency flag", status.emerg_lock, 32'h1);
        @(posedge sys_clk) emergency <= 1'b0;
        wait_st("emergency release", 2'h1, 4);
        repeat (100) @(posedge sys_clk);
        wait_st("normal threshold", 2'h1, 0);
        $display("emergency done");
        apb(1'b1, 8'h10, 32'h3c);
        apb(1'b1, 8'h14, 32'h3);
        @(posedge sys_clk) power <= 16'hffff;
        wait_st("trip before outage", 2'h3, 200);
        @(posedge sys_clk) power <= 16'h0000;
        power_restored <= 1'b1;
        @(posedge sys_clk) power_restored <= 1'b0;
        wait_st("power on close", 2'h1, 200);
        apb(1'b1, 8'h18, 32'h105);
        apb(1'b0, 8'h18, 32'h0);
        chk("window clamp", rd, 32'h3c);
        $display("power return done");
        close_out();
    end
endmodule : tb
`default_nettype wire
